/* File: shared/conv_ctrl_pkg.sv */
// Package: constants for the converter input, clock and conversion control block
package conv_ctrl_pkg;

  // =====================================================
  // Source kind select codes (manual / single-channel modes)
  localparam logic [2:0] SRC_EXT0     = 3'h0;
  localparam logic [2:0] SRC_BANDGAP  = 3'h1;
  localparam logic [2:0] SRC_AMP      = 3'h2;
  localparam logic [2:0] SRC_AMP_ALT  = 3'h3;
  localparam logic [2:0] SRC_GROUND   = 3'h4;

  // =====================================================
  // Two-channel internal signal select codes
  localparam logic [3:0] AUTO_INT_BG      = 4'h0;
  localparam logic [3:0] AUTO_INT_AMP     = 4'h1;
  localparam logic [3:0] AUTO_INT_AMP_ALT = 4'h2;
  localparam logic [3:0] AUTO_INT_GROUND  = 4'h3;

  // =====================================================
  // Analog mux one-hot positions for internal sources
  localparam int INT_W       = 4;
  localparam int INT_BG_BIT  = 0;
  localparam int INT_AMP_BIT = 1;
  localparam int INT_ALT_BIT = 2;
  localparam int INT_GND_BIT = 3;

  // =====================================================
  // External channel geometry
  localparam int          PIN_COUNT   = 14;
  localparam logic [3:0]  CHAN_HOLE   = 4'h7;  // Reserved code, no pin
  localparam logic [3:0]  CHAN_LAST   = 4'hD;  // Highest real pin code

  // =====================================================
  // Conversion timing in conversion clocks
  localparam int          SAMPLE_CLKS  = 4;
  localparam int          CONVERT_CLKS = 12;
  localparam int          TOTAL_CLKS   = SAMPLE_CLKS + CONVERT_CLKS;
  localparam logic [4:0]  SAMPLE_LAST  = 5'(SAMPLE_CLKS - 1);
  localparam logic [4:0]  TOTAL_LAST   = 5'(TOTAL_CLKS - 1);

  // =====================================================
  // Divider
  localparam int          DIV_SEL_W   = 3;
  localparam int          DIV_CNT_W   = 7;    // Covers divide by 128
  localparam int          RESULT_W    = 12;
  localparam logic [2:0]  AUTO_MANUAL = 3'h0;

  // =====================================================
  // Conversion sequencer states
  typedef enum logic [1:0] {
    ST_IDLE   = 2'b00,
    ST_ARMED  = 2'b01,
    ST_SAMPLE = 2'b10,
    ST_CONV   = 2'b11
  } conv_state_e;

endpackage

/* File: rtl/conv_ctrl.sv */
// Module: converter input routing, conversion clock, power and manual conversion sequencing
//
// Contract
// R1: A pin chosen as analog input has all its other functions disabled.
// R2: Pull-high resistor is disconnected while the pin is an analog input.
// R3: Analog input selection overrides the pin's port direction setting.
// R4: 3-bit source select: 000,101-111 external; 001 bandgap; 010/011 amps; 100 ground.
// R5: Channel codes 0-6 and 8-13 pick pins; 1110/1111 float.
// R6: Two-channel mode: each channel has own source bit and 4-bit selector.
// R7: Two-channel internal: 0001 amp, 0010 alt amp, 0011 ground, else bandgap.
// R8: Two-channel external uses the manual pin mapping; 1110/1111 float.
// R9: Internal signal routed means external channel path is disconnected.
// R10: Conversion clock = system clock divided by 2^select, 1 to 128.
// R11: Software keeps conversion clock period within 0.5 to 10 us.
// R12: Converter powered only while enable high; software waits settling delay.
// R13: Conversion is 4 sampling clocks plus 12 converting clocks.
// R14: Auto count 000 means manual mode using manual selects.
// R15: Software pulses start high then low; one conversion follows.
// R16: Busy flag set when conversion starts, cleared on completion.
// R17: Completion sets interrupt request flag; raises interrupt if enabled.
// R18: Result held in high and low result registers after completion.
// R19: Start pulse ignored while busy or powered down.
// R20: Start sampled on system clock; sampling begins on next conversion clock edge.
`timescale 1ns/1ps

module conv_ctrl
  import conv_ctrl_pkg::*;
#(
  parameter int PINS = conv_ctrl_pkg::PIN_COUNT
) (
  input  wire logic                               mclk,
  input  wire logic                               rst,
  // Configuration
  input  wire logic [conv_ctrl_pkg::DIV_SEL_W-1:0] conv_clk_div_sel,
  input  wire logic                               conv_power_en,
  input  wire logic [2:0]                         auto_conv_count,
  input  wire logic                               auto_two_chan,
  input  wire logic                               auto_chan2_active,
  input  wire logic [2:0]                         src_kind_sel,
  input  wire logic [3:0]                         ext_chan_sel,
  input  wire logic                               auto_ch1_src_kind,
  input  wire logic [3:0]                         auto_ch1_sig_sel,
  input  wire logic                               auto_ch2_src_kind,
  input  wire logic [3:0]                         auto_ch2_sig_sel,
  input  wire logic [PINS-1:0]                    pin_func_sel,
  input  wire logic [PINS-1:0]                    port_pull_en,
  input  wire logic [PINS-1:0]                    port_out_en,
  // Manual start and completion handling
  input  wire logic                               conv_start,
  input  wire logic                               conv_int_en,
  input  wire logic                               conv_int_flag_clr,
  // Converter core result
  input  wire logic [conv_ctrl_pkg::RESULT_W-1:0] core_result,
  // Outputs
  output logic [PINS-1:0]                         ext_chan_connect,
  output logic [conv_ctrl_pkg::INT_W-1:0]         int_sig_connect,
  output logic [PINS-1:0]                         pin_digital_en,
  output logic [PINS-1:0]                         pin_pull_act,
  output logic [PINS-1:0]                         pin_drive_en,
  output logic                                    conv_power,
  output logic                                    conv_clk_tick,
  output logic                                    conv_sampling,
  output logic                                    conv_busy_flag,
  output logic                                    conv_int_flag,
  output logic                                    conv_irq,
  output logic [3:0]                              result_high,
  output logic [7:0]                              result_low
);
  import conv_ctrl_pkg::*;

  // =====================================================
  // Elaboration check
  if (PINS != PIN_COUNT) begin : g_bad_pins
    $error("conv_ctrl: PINS must equal the number of analog pins");
  end

  // Divider counter must span the largest division
  if (((1 << DIV_SEL_W) - 1) > DIV_CNT_W) begin : g_bad_div
    $error("conv_ctrl: divider counter too narrow for the select range");
  end

  // Phase counter must hold every conversion clock index
  if (TOTAL_CLKS > (1 << $bits(SAMPLE_LAST))) begin : g_bad_phase
    $error("conv_ctrl: phase counter too narrow for the conversion length");
  end

  // Both phases need at least one conversion clock
  if (SAMPLE_CLKS < 1 || CONVERT_CLKS < 1) begin : g_bad_timing
    $error("conv_ctrl: sampling and conversion phases must not be empty");
  end

  // Result registers take the whole core word
  if (RESULT_W != $bits(result_high) + $bits(result_low)) begin : g_bad_result
    $error("conv_ctrl: result width must match the result registers");
  end

  // Highest channel code must name a real pin
  if (int'(CHAN_LAST) >= PINS) begin : g_bad_chan
    $error("conv_ctrl: channel code range exceeds the pin count");
  end

  // Internal source positions must fit the one-hot connect vector
  if (INT_GND_BIT >= INT_W) begin : g_bad_int
    $error("conv_ctrl: internal source position outside the connect vector");
  end

  // Internal source codes must form one contiguous range
  if (SRC_GROUND < SRC_BANDGAP) begin : g_bad_src
    $error("conv_ctrl: internal source codes out of order");
  end

  // =====================================================
  // Decode helpers

  // Maps a 4-bit channel code onto a one-hot pin vector; holes float
  // Code 0111 and codes above 1101 close no switch at all
  function automatic logic [PINS-1:0] chan_decode(input logic [3:0] code);
    logic [PINS-1:0] v;
    v = '0;
    if (code != CHAN_HOLE && code <= CHAN_LAST) begin
      v[code] = 1'b1;
    end
    return v;
  endfunction

  // Internal source one-hot from the two-channel selector
  // Unlisted codes fall back to the bandgap, so the node never floats
  function automatic logic [INT_W-1:0] auto_int_decode(input logic [3:0] code);
    logic [INT_W-1:0] v;
    v = '0;
    unique case (code)
      AUTO_INT_AMP:     v[INT_AMP_BIT] = 1'b1;
      AUTO_INT_AMP_ALT: v[INT_ALT_BIT] = 1'b1;
      AUTO_INT_GROUND:  v[INT_GND_BIT] = 1'b1;
      default:          v[INT_BG_BIT]  = 1'b1;
    endcase
    return v;
  endfunction

  // =====================================================
  // Input routing

  // Manual and single-channel routing
  // Codes 101-111 lie outside the internal range and pick a pin
  wire             manual_mode = (auto_conv_count == AUTO_MANUAL);  // see R14
  wire             man_is_int  = (src_kind_sel >= SRC_BANDGAP) && (src_kind_sel <= SRC_GROUND);
  wire [INT_W-1:0] man_int     = {src_kind_sel == SRC_GROUND,
                                  src_kind_sel == SRC_AMP_ALT,
                                  src_kind_sel == SRC_AMP,
                                  src_kind_sel == SRC_BANDGAP};  // see R4

  // Two-channel routing; active channel picks its own bit and selector
  // Single-channel auto mode keeps the manual selects
  wire             two_chan    = auto_two_chan && !manual_mode;
  wire             ach_ext     = auto_chan2_active ? auto_ch2_src_kind : auto_ch1_src_kind;
  wire [3:0]       ach_sel     = auto_chan2_active ? auto_ch2_sig_sel : auto_ch1_sig_sel;  // see R6

  // Effective source once the mode is resolved
  wire             use_int     = two_chan ? !ach_ext : man_is_int;
  wire [INT_W-1:0] next_int    = !use_int ? '0 : (two_chan ? auto_int_decode(ach_sel) : man_int);  // see R7
  wire [3:0]       ext_code    = two_chan ? ach_sel : ext_chan_sel;  // see R8
  // Internal source never shares the node with an external pin
  // Power off opens every pin switch as well
  wire [PINS-1:0]  ext_dec     = chan_decode(ext_code);  // see R5
  wire [PINS-1:0]  next_ext    = (use_int || !conv_power_en) ? '0 : (ext_dec & pin_func_sel);  // see R9

  // Pin function overrides for analog-selected pins
  // Port settings are kept; only their effect on the pin is masked
  wire [PINS-1:0]  next_dig    = ~pin_func_sel;                // see R1
  wire [PINS-1:0]  next_pull   = port_pull_en & ~pin_func_sel; // see R2
  wire [PINS-1:0]  next_drive  = port_out_en & ~pin_func_sel;  // see R3

  // Registered routing outputs
  // Reset opens every switch and hands each pin to its logic function
  always_ff @(posedge mclk) begin
    if (rst) begin
      ext_chan_connect <= '0;
      int_sig_connect  <= '0;
      pin_digital_en   <= '1;
      pin_pull_act     <= '0;
      pin_drive_en     <= '0;
    end else begin
      ext_chan_connect <= next_ext;
      int_sig_connect  <= next_int;
      pin_digital_en   <= next_dig;
      pin_pull_act     <= next_pull;
      pin_drive_en     <= next_drive;
    end
  end

  // =====================================================
  // Conversion clock divider

  // Terminal count per select; >= lets a shorter select take over at once
  logic [DIV_CNT_W-1:0] div_cnt;
  wire  [DIV_CNT_W-1:0] div_last = DIV_CNT_W'((8'h01 << conv_clk_div_sel) - 8'h01);  // see R10
  wire                  div_hit  = (div_cnt >= div_last);
  wire  [DIV_CNT_W-1:0] next_div = (!conv_power_en || div_hit) ? '0 : div_cnt + 1'b1;
  wire                  next_tick = conv_power_en && div_hit;  // see R10

  // Counts system clocks; one tick per conversion clock
  always_ff @(posedge mclk) begin
    if (rst) begin
      div_cnt       <= '0;
      conv_clk_tick <= 1'b0;
    end else begin
      div_cnt       <= next_div;
      conv_clk_tick <= next_tick;
    end
  end

  // Power follows the enable bit directly; settling is left to software
  // A start inside the settling time is not refused here
  always_ff @(posedge mclk) begin
    if (rst) begin
      conv_power <= 1'b0;
    end else begin
      conv_power <= conv_power_en;  // see R12
    end
  end

  // =====================================================
  // Start pulse detection

  // A start counts on the return to low, after the bit was high
  logic start_d;
  wire  start_fall = start_d && !conv_start;  // see R15

  // Start history; resets low like the idle bit, so no false fall
  always_ff @(posedge mclk) begin
    if (rst) begin
      start_d <= 1'b0;
    end else begin
      start_d <= conv_start;
    end
  end

  // =====================================================
  // Sequencer

  // Sequencer state, phase count and completion strobe
  conv_state_e state;
  conv_state_e next_state;
  logic [4:0]  phase_cnt;
  logic [4:0]  next_phase;
  logic        done;

  // Start is honoured only in manual mode, powered and idle
  // Falls seen while busy are dropped, not queued
  wire accept = start_fall && manual_mode && conv_power_en && (state == ST_IDLE);  // see R19

  // Armed waits for a tick, then 4 sampling and 12 converting ticks
  // Power loss returns to idle with no completion
  always_comb begin
    next_state = state;
    next_phase = phase_cnt;
    done       = 1'b0;
    if (!conv_power_en) begin
      next_state = ST_IDLE;
      next_phase = '0;
    end else begin
      // Phase counts ticks through both phases
      unique case (state)
        ST_IDLE: begin
          if (accept) begin
            next_state = ST_ARMED;
          end
        end
        ST_ARMED: begin
          if (conv_clk_tick) begin
            next_state = ST_SAMPLE;  // see R20
            next_phase = '0;
          end
        end
        ST_SAMPLE: begin
          if (conv_clk_tick) begin
            next_phase = phase_cnt + 5'h01;
            if (phase_cnt == SAMPLE_LAST) begin
              next_state = ST_CONV;  // see R13
            end
          end
        end
        ST_CONV: begin
          if (conv_clk_tick) begin
            next_phase = phase_cnt + 5'h01;
            if (phase_cnt == TOTAL_LAST) begin
              next_state = ST_IDLE;  // see R13
              next_phase = '0;
              done       = 1'b1;
            end
          end
        end
      endcase
    end
  end

  // State and phase counter
  // Phase runs 0-3 while sampling and 4-15 while converting
  always_ff @(posedge mclk) begin
    if (rst) begin
      state     <= ST_IDLE;
      phase_cnt <= '0;
    end else begin
      state     <= next_state;
      phase_cnt <= next_phase;
    end
  end

  // =====================================================
  // Status, interrupt and result

  // Status next values; a completion and a clear together leave the flag set
  wire next_busy = (next_state != ST_IDLE);  // see R16
  wire next_samp = (next_state == ST_SAMPLE);  // see R13
  wire next_flag = done || (conv_int_flag && !conv_int_flag_clr);  // see R17
  wire next_irq  = next_flag && conv_int_en;  // see R17

  // Registered status and interrupt outputs
  always_ff @(posedge mclk) begin
    if (rst) begin
      conv_busy_flag <= 1'b0;
      conv_sampling  <= 1'b0;
      conv_int_flag  <= 1'b0;
      conv_irq       <= 1'b0;
    end else begin
      conv_busy_flag <= next_busy;
      conv_sampling  <= next_samp;
      conv_int_flag  <= next_flag;
      conv_irq       <= next_irq;
    end
  end

  // Result captured at completion and held until the next one
  // An aborted conversion leaves the previous result in place
  always_ff @(posedge mclk) begin
    if (rst) begin
      result_high <= 4'h0;
      result_low  <= 8'h00;
    end else if (done) begin
      result_high <= core_result[11:8];  // see R18
      result_low  <= core_result[7:0];
    end
  end

endmodule

/* File: test/conv_ctrl_assertions.sv */
// Checker: port-level assertions for the conversion control block
`timescale 1ns/1ps
module conv_ctrl_assertions (
  input wire logic        mclk,
  input wire logic        rst,
  input wire logic [2:0]  conv_clk_div_sel,
  input wire logic        conv_power_en,
  input wire logic [2:0]  auto_conv_count,
  input wire logic        conv_start,
  input wire logic [11:0] core_result,
  input wire logic [13:0] pin_func_sel,
  input wire logic [13:0] port_pull_en,
  input wire logic [13:0] ext_chan_connect,
  input wire logic [3:0]  int_sig_connect,
  input wire logic [13:0] pin_digital_en,
  input wire logic [13:0] pin_pull_act,
  input wire logic        conv_clk_tick,
  input wire logic        conv_busy_flag,
  input wire logic        conv_int_flag,
  input wire logic [3:0]  result_high,
  input wire logic [7:0]  result_low
);
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  // =====================================================
  // Pin handover and routing
  property p_dig; 1 |=> pin_digital_en == ~$past(pin_func_sel); endproperty
  a_dig: assert property (p_dig) else $error("digital enable wrong");
  property p_pull; 1 |=> pin_pull_act == $past(port_pull_en & ~pin_func_sel); endproperty
  a_pull: assert property (p_pull) else $error("pull not released");
  property p_excl; int_sig_connect != 4'h0 |-> ext_chan_connect == 14'h0; endproperty
  a_excl: assert property (p_excl) else $error("both sources joined");
  // =====================================================
  // Start, refusal, completion and divider period
  property p_start;
    $past(conv_start) && !conv_start && !conv_busy_flag && conv_power_en
      && $past(conv_power_en) && auto_conv_count == 3'h0 |=> conv_busy_flag;
  endproperty
  a_start: assert property (p_start) else $error("start not taken");
  property p_refuse;
    (auto_conv_count != 3'h0 || !conv_power_en && !$past(conv_power_en))
      && !conv_busy_flag |=> !conv_busy_flag;
  endproperty
  a_refuse: assert property (p_refuse) else $error("start not refused");
  property p_done;
    $fell(conv_busy_flag) && conv_power_en && $past(conv_power_en) |-> conv_int_flag;
  endproperty
  a_done: assert property (p_done) else $error("flag not set at done");
  property p_res;
    $fell(conv_busy_flag) && conv_power_en && $past(conv_power_en)
      |-> {result_high, result_low} == $past(core_result);
  endproperty
  a_res: assert property (p_res) else $error("result not latched");
  property p_tick;
    (conv_clk_div_sel == 3'h2 && conv_power_en)[*6] ##0 conv_clk_tick
      |=> (!conv_clk_tick)[*3] ##1 conv_clk_tick
      or ##[0:3] (conv_clk_div_sel != 3'h2 || !conv_power_en);
  endproperty
  a_tick: assert property (p_tick) else $error("divide by 4 period wrong");
endmodule

bind conv_ctrl conv_ctrl_assertions i_conv_ctrl_assertions (.*);

/* File: test/conv_core_model.sv */
// Partner model: converter core data seen by the control block
`timescale 1ns/1ps
module conv_core_model (
  input  wire logic        mclk,
  input  wire logic        powered,
  input  wire logic [11:0] value,
  output logic      [11:0] core_result
);
  logic [11:0] junk = 12'h000;
  // Unpowered core shows a changing pattern, never a stale value
  always_ff @(posedge mclk) junk <= ~junk;
  assign core_result = powered ? value : junk;
endmodule

/* File: test/conv_ctrl_tb.sv */
// Testbench: routing, pin handover, divider and manual conversion
`timescale 1ns/1ps
module conv_ctrl_tb;
  import conv_ctrl_pkg::*;
  logic        mclk = 1'b0, rst = 1'b1, pwr = 1'b0, start = 1'b0, ien = 1'b0;
  logic        iclr = 1'b0, two = 1'b0, ch2 = 1'b0, k1 = 1'b0, k2 = 1'b0;
  logic [2:0]  sel = 3'h0, cnt = 3'h0, src = 3'h0;
  logic [3:0]  chan = 4'h0, s1 = 4'h0, s2 = 4'h0, isc, rh;
  logic [13:0] fsel = 14'h3FFF, pull = 14'h0000, oen = 14'h0000, ext, dig, pact, drv;
  logic [11:0] val = 12'hA5C;
  wire  [11:0] core;
  logic [7:0]  rl;
  logic        cpow, tick, samp, busy, flag, irq;
  int          bad_count = 0, check_count = 0, cyc = 0, n, m;

  conv_ctrl i_conv_ctrl (
    .mclk(mclk), .rst(rst), .conv_clk_div_sel(sel), .conv_power_en(pwr),
    .auto_conv_count(cnt), .auto_two_chan(two), .auto_chan2_active(ch2),
    .src_kind_sel(src), .ext_chan_sel(chan), .auto_ch1_src_kind(k1),
    .auto_ch1_sig_sel(s1), .auto_ch2_src_kind(k2), .auto_ch2_sig_sel(s2),
    .pin_func_sel(fsel), .port_pull_en(pull), .port_out_en(oen), .conv_start(start),
    .conv_int_en(ien), .conv_int_flag_clr(iclr), .core_result(core),
    .ext_chan_connect(ext), .int_sig_connect(isc), .pin_digital_en(dig),
    .pin_pull_act(pact), .pin_drive_en(drv), .conv_power(cpow), .conv_clk_tick(tick),
    .conv_sampling(samp), .conv_busy_flag(busy), .conv_int_flag(flag), .conv_irq(irq),
    .result_high(rh), .result_low(rl)
  );
  conv_core_model i_conv_core_model (.mclk(mclk), .powered(cpow), .value(val),
                                     .core_result(core));

  always #10 mclk = ~mclk;
  // Hang guard
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 20000) begin
      bad_count++;
      final_report;
    end
  end

  // =====================================================
  // Helpers
  task step; @(negedge mclk); endtask
  task pulse; start = 1'b1; step; start = 1'b0; step; endtask
  task clear; iclr = 1'b1; step; iclr = 1'b0; step; endtask
  task chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  function automatic logic [13:0] pin_exp(input logic [3:0] c);
    pin_exp = (c == 4'h7 || c > 4'hD) ? 14'h0000 : 14'h0001 << c;
  endfunction
  function automatic logic [3:0] int_exp(input logic [3:0] c);
    int_exp = c == 4'h1 ? 4'h2 : c == 4'h2 ? 4'h4 : c == 4'h3 ? 4'h8 : 4'h1;
  endfunction
  // One manual conversion with an extra start pulse in mid-run
  task conv(input logic [2:0] s);
    sel = s;
    pulse;
    n = 0;
    while (busy !== 1'b1 && n < 10) begin
      step;
      n++;
    end
    chk(busy, 1'b1);
    n = 0;
    m = 0;
    while (busy === 1'b1 && n < 5000) begin
      m += samp;
      start = (n == 5);
      step;
      n++;
    end
    chk(m, SAMPLE_CLKS << s);
    chk(n >= (TOTAL_CLKS << s) && n <= ((TOTAL_CLKS + 1) << s), 1'b1);
    chk(flag, 1'b1);
    chk({rh, rl}, val);
  endtask
  task final_report;
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // =====================================================
  // Main sequence
  initial begin
    repeat (20) @(posedge mclk);
    step;
    chk(dig, 14'h3FFF);
    rst = 1'b0;
    pwr = 1'b1;
    chan = 4'h5;
    for (int i = 0; i < 8; i++) begin
      src = i[2:0];
      step;
      chk(isc, (i >= 1 && i <= 4) ? 4'h1 << (i - 1) : 4'h0);
      chk(ext, (i >= 1 && i <= 4) ? 14'h0000 : 14'h0020);
    end
    src = 3'h0;
    for (int i = 0; i < 16; i++) begin
      chan = i[3:0];
      step;
      chk(ext, pin_exp(chan));
    end
    // Two-channel mode, channel 1 internal, channel 2 external
    cnt = 3'h1;
    two = 1'b1;
    k2 = 1'b1;
    for (int i = 0; i < 16; i++) begin
      s1 = i[3:0];
      s2 = ~s1;
      ch2 = 1'b0;
      step;
      chk(isc, int_exp(s1));
      chk(ext, 14'h0000);
      ch2 = 1'b1;
      step;
      chk(ext, pin_exp(s2));
    end
    cnt = 3'h0;
    two = 1'b0;
    chan = 4'h0;
    fsel = 14'h3FFE;
    pull = 14'h3FFF;
    oen = 14'h3FFF;
    step;
    chk(ext, 14'h0000);
    chk(dig, 14'h0001);
    chk(pact, 14'h0001);
    chk(drv, 14'h0001);
    fsel = 14'h3FFF;
    ien = 1'b1;
    // Selects 5 and 6 give a 640 ns and a 1.28 us conversion clock
    conv(3'h5);
    chk(irq, 1'b1);
    repeat (20) step;
    chk(busy, 1'b0);
    clear;
    chk({flag, irq}, 2'b00);
    ien = 1'b0;
    val = 12'h3C1;
    conv(3'h6);
    chk(irq, 1'b0);
    clear;
    cnt = 3'h1;
    pulse;
    repeat (10) step;
    chk(busy, 1'b0);
    cnt = 3'h0;
    pulse;
    repeat (10) step;
    pwr = 1'b0;
    repeat (3) step;
    chk(cpow, 1'b0);
    chk({busy, flag, rh, rl}, {2'b00, 12'h3C1});
    pulse;
    repeat (10) step;
    chk(busy, 1'b0);
    sel = 3'h0;
    pwr = 1'b1;
    repeat (4) step;
    chk(cpow, 1'b1);
    for (int i = 0; i < 8; i++) begin
      sel = i[2:0];
      m = 0;
      repeat (256) begin
        step;
        m += tick;
      end
      chk(m, 256 >> i);
    end
    final_report;
  end
endmodule
